// File: logic/tca_pkg.sv
// Package: register map, reset values and depth codes for the text color attribute bank
package tca_pkg;
  // ==========================================
  // Register byte addresses
  localparam logic [7:0] ADDR_RSVD_A0 = 8'hce;
  localparam logic [7:0] ADDR_RSVD_A1 = 8'hcf;
  localparam logic [7:0] ADDR_LINE_GAP = 8'hd0;
  localparam logic [7:0] ADDR_CHAR_SPACING = 8'hd1;
  localparam logic [7:0] ADDR_FORE_RED = 8'hd2;
  localparam logic [7:0] ADDR_FORE_GREEN = 8'hd3;
  localparam logic [7:0] ADDR_FORE_BLUE = 8'hd4;
  localparam logic [7:0] ADDR_BACK_RED = 8'hd5;
  localparam logic [7:0] ADDR_BACK_GREEN = 8'hd6;
  localparam logic [7:0] ADDR_BACK_BLUE = 8'hd7;
  localparam logic [7:0] ADDR_RSVD_B0 = 8'hd8;
  localparam logic [7:0] ADDR_RSVD_B1 = 8'hd9;
  localparam logic [7:0] ADDR_RSVD_B2 = 8'hda;
  localparam logic [7:0] ADDR_GLYPH_START0 = 8'hdb;
  localparam logic [7:0] ADDR_GLYPH_START1 = 8'hdc;
  localparam logic [7:0] ADDR_GLYPH_START2 = 8'hdd;
  localparam logic [7:0] ADDR_GLYPH_START3 = 8'hde;
  localparam logic [7:0] ADDR_ATTR_STATUS = 8'he8;

  // ==========================================
  // Field widths and positions
  localparam int LINE_GAP_W = 5;
  localparam int CHAR_SPACING_W = 6;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_VIOL_BIT = 1;

  // ==========================================
  // Reset values
  localparam logic [7:0] FORE_RESET = 8'hff;
  localparam logic [7:0] BACK_RESET = 8'h00;
  localparam logic [7:0] REG_ZERO = 8'h00;

  // ==========================================
  // Color depth codes
  typedef enum logic [1:0] {
    TCA_DEPTH_8 = 2'h0,
    TCA_DEPTH_16 = 2'h1,
    TCA_DEPTH_24 = 2'h2
  } tca_depth_e;
endpackage : tca_pkg

// File: logic/tca_color_pack.sv
// Packs one red, green, blue byte triple into the pixel word of the selected depth
`timescale 1ns/1ps
module tca_color_pack
  import tca_pkg::*;
(
  input wire logic [1:0] depth,
  input wire logic [7:0] red,
  input wire logic [7:0] green,
  input wire logic [7:0] blue,
  output logic [23:0] packed_color
);
  // ==========================================
  // Depth mapping
  always_comb begin
    unique case (depth)
      TCA_DEPTH_8: packed_color = {16'h0000, red[7:5], green[7:5], blue[7:6]}; // [R04] [R05] [R06]
      TCA_DEPTH_16: packed_color = {8'h00, red[7:3], green[7:2], blue[7:3]}; // [R04] [R05] [R06]
      TCA_DEPTH_24: packed_color = {red, green, blue}; // [R04] [R05] [R06]
      default: packed_color = {red, green, blue};
    endcase
  end
endmodule : tca_color_pack

// File: logic/tca_text_color_attr.sv
// Text engine color and spacing attribute registers with background fill pixel selector
//
// Contract
// (R01) A five-bit line gap in pixels is held and offered for rows inserted at window wrap.
// (R02) A six-bit character spacing is held, code n meaning n pixels after each character.
// (R03) Gap and spacing pixels take the background color and their counts are never scaled.
// (R04) Red bytes map to bits 7:5, 7:3 or 7:0 at 8, 16 or 24 bits per pixel.
// (R05) Green bytes map to bits 7:5, 7:2 or 7:0 at 8, 16 or 24 bits per pixel.
// (R06) Blue bytes map to bits 7:6, 7:3 or 7:0 at 8, 16 or 24 bits per pixel.
// (R07) Three foreground bytes feed drawing, text and expansion and reset to all ones.
// (R08) Three background bytes feed text and expansion and reset to zero.
// (R09) Software should never set background equal to foreground.
// (R10) The glyph memory start address is 32 bits from four upward byte registers, reset zero.
// (R11) Software lays out glyph data and the engine fetches from the start address.
// (R12) Attributes are changed only while the engine busy flag is low; a write while busy still lands and sets the violation flag.
// (R13) Reserved addresses and unused line gap bits read zero and ignore writes.
// (R14) With chroma key set background pixels keep the canvas, else they get background color.
// (R15) The top address byte sits at the address right after the third byte.
`timescale 1ns/1ps
module tca_text_color_attr
  import tca_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic engine_busy,
  input wire logic [1:0] color_depth,
  input wire logic chroma_key_en,
  input wire logic px_valid,
  input wire logic px_is_space,
  input wire logic px_glyph_bit,
  output logic px_out_valid,
  output logic px_out_write,
  output logic [23:0] px_out_color,
  output logic [LINE_GAP_W-1:0] line_gap,
  output logic [CHAR_SPACING_W-1:0] char_spacing,
  output logic [23:0] fore_color,
  output logic [23:0] back_color,
  output logic [31:0] glyph_start_address
);
  // ==========================================
  // Register state
  logic [LINE_GAP_W-1:0] line_gap_q, line_gap_d;
  logic [7:0] spacing_q, spacing_d;
  logic [7:0] fore_red_q, fore_red_d;
  logic [7:0] fore_green_q, fore_green_d;
  logic [7:0] fore_blue_q, fore_blue_d;
  logic [7:0] back_red_q, back_red_d;
  logic [7:0] back_green_q, back_green_d;
  logic [7:0] back_blue_q, back_blue_d;
  logic [31:0] glyph_q, glyph_d;
  logic viol_q, viol_d;
  logic [7:0] rdata_q, rdata_d;
  logic attr_write;

  // Attribute register writes checked against the busy flag; writes still land while busy
  always_comb begin
    attr_write = reg_wr && (reg_addr >= ADDR_LINE_GAP) && (reg_addr <= ADDR_BACK_BLUE);
  end

  always_comb begin
    line_gap_d = line_gap_q;
    spacing_d = spacing_q;
    fore_red_d = fore_red_q;
    fore_green_d = fore_green_q;
    fore_blue_d = fore_blue_q;
    back_red_d = back_red_q;
    back_green_d = back_green_q;
    back_blue_d = back_blue_q;
    glyph_d = glyph_q;
    viol_d = viol_q;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_LINE_GAP: line_gap_d = reg_wdata[LINE_GAP_W-1:0]; // [R01]
        ADDR_CHAR_SPACING: spacing_d = reg_wdata; // [R02]
        ADDR_FORE_RED: fore_red_d = reg_wdata; // [R07]
        ADDR_FORE_GREEN: fore_green_d = reg_wdata; // [R07]
        ADDR_FORE_BLUE: fore_blue_d = reg_wdata; // [R07]
        ADDR_BACK_RED: back_red_d = reg_wdata; // [R08]
        ADDR_BACK_GREEN: back_green_d = reg_wdata; // [R08]
        ADDR_BACK_BLUE: back_blue_d = reg_wdata; // [R08]
        ADDR_GLYPH_START0: glyph_d[7:0] = reg_wdata; // [R10]
        ADDR_GLYPH_START1: glyph_d[15:8] = reg_wdata; // [R10]
        ADDR_GLYPH_START2: glyph_d[23:16] = reg_wdata; // [R10]
        ADDR_GLYPH_START3: glyph_d[31:24] = reg_wdata; // [R10] [R15]
        ADDR_ATTR_STATUS: begin
          if (reg_wdata[STATUS_VIOL_BIT]) begin
            viol_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Late change flagged; a fresh event beats the clear
    if (attr_write && engine_busy) begin
      viol_d = 1'b1; // [R12]
    end
  end

  // ==========================================
  // Read path
  always_comb begin
    rdata_d = REG_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_LINE_GAP: rdata_d = {{(8-LINE_GAP_W){1'b0}}, line_gap_q}; // [R13]
        ADDR_CHAR_SPACING: rdata_d = spacing_q;
        ADDR_FORE_RED: rdata_d = fore_red_q;
        ADDR_FORE_GREEN: rdata_d = fore_green_q;
        ADDR_FORE_BLUE: rdata_d = fore_blue_q;
        ADDR_BACK_RED: rdata_d = back_red_q;
        ADDR_BACK_GREEN: rdata_d = back_green_q;
        ADDR_BACK_BLUE: rdata_d = back_blue_q;
        ADDR_GLYPH_START0: rdata_d = glyph_q[7:0];
        ADDR_GLYPH_START1: rdata_d = glyph_q[15:8];
        ADDR_GLYPH_START2: rdata_d = glyph_q[23:16];
        ADDR_GLYPH_START3: rdata_d = glyph_q[31:24];
        ADDR_ATTR_STATUS: begin
          rdata_d[STATUS_BUSY_BIT] = engine_busy;
          rdata_d[STATUS_VIOL_BIT] = viol_q;
        end
        default: rdata_d = REG_ZERO; // [R13]
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_gap_q <= '0;
      spacing_q <= REG_ZERO;
      fore_red_q <= FORE_RESET; // [R07]
      fore_green_q <= FORE_RESET; // [R07]
      fore_blue_q <= FORE_RESET; // [R07]
      back_red_q <= BACK_RESET; // [R08]
      back_green_q <= BACK_RESET; // [R08]
      back_blue_q <= BACK_RESET; // [R08]
      glyph_q <= '0; // [R10]
      viol_q <= 1'b0;
      rdata_q <= REG_ZERO;
    end else begin
      line_gap_q <= line_gap_d;
      spacing_q <= spacing_d;
      fore_red_q <= fore_red_d;
      fore_green_q <= fore_green_d;
      fore_blue_q <= fore_blue_d;
      back_red_q <= back_red_d;
      back_green_q <= back_green_d;
      back_blue_q <= back_blue_d;
      glyph_q <= glyph_d;
      viol_q <= viol_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // Depth packing
  logic [23:0] fore_packed;
  logic [23:0] back_packed;

  tca_color_pack u_fore_pack (
    .depth(color_depth),
    .red(fore_red_q),
    .green(fore_green_q),
    .blue(fore_blue_q),
    .packed_color(fore_packed)
  );

  tca_color_pack u_back_pack (
    .depth(color_depth),
    .red(back_red_q),
    .green(back_green_q),
    .blue(back_blue_q),
    .packed_color(back_packed)
  );

  // ==========================================
  // Pixel selector
  logic px_valid_q, px_valid_d;
  logic px_write_q, px_write_d;
  logic [23:0] px_color_q, px_color_d;
  logic px_is_back;

  always_comb begin
    px_is_back = px_is_space || !px_glyph_bit; // [R03]
    px_valid_d = px_valid;
    px_write_d = 1'b0;
    px_color_d = px_color_q;
    if (px_valid) begin
      px_color_d = px_is_back ? back_packed : fore_packed; // [R03]
      px_write_d = !(px_is_back && chroma_key_en); // [R14]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      px_valid_q <= 1'b0;
      px_write_q <= 1'b0;
      px_color_q <= '0;
    end else begin
      px_valid_q <= px_valid_d;
      px_write_q <= px_write_d;
      px_color_q <= px_color_d;
    end
  end

  // ==========================================
  // Outputs
  assign reg_rdata = rdata_q;
  assign px_out_valid = px_valid_q;
  assign px_out_write = px_write_q;
  assign px_out_color = px_color_q;
  // Raw pixel counts, never multiplied by enlargement
  assign line_gap = line_gap_q; // [R01] [R03]
  assign char_spacing = spacing_q[CHAR_SPACING_W-1:0]; // [R02] [R03]
  assign fore_color = fore_packed;
  assign back_color = back_packed;
  assign glyph_start_address = glyph_q; // [R11]

  // ==========================================
  // Assertions
  logic back_touched_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      back_touched_q <= 1'b0;
    end else if (reg_wr && (reg_addr >= ADDR_BACK_RED) && (reg_addr <= ADDR_BACK_BLUE)) begin
      back_touched_q <= 1'b1;
    end
  end

  sequence gap_write_s;
    reg_wr && reg_addr == ADDR_LINE_GAP;
  endsequence

  sequence gap_read_s;
    reg_rd && reg_addr == ADDR_LINE_GAP;
  endsequence

  property gap_roundtrip_p;
    @(posedge mclk) disable iff (!rst_n)
      gap_write_s ##2 gap_read_s |=> reg_rdata == ($past(reg_wdata, 3) & 8'h1f);
  endproperty

  line_gap_rt_a: assert property (gap_roundtrip_p) // [R01] [R13]
    else $error("line gap readback wrong");

  spacing_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R02]
    reg_wr && reg_addr == ADDR_CHAR_SPACING |=> char_spacing == $past(reg_wdata[5:0]))
    else $error("char spacing not updated");

  space_uses_back_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R03]
    px_valid && px_is_space |=> px_out_valid && px_out_color == $past(back_packed))
    else $error("spacing pixel not background");

  depth_map_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R04] [R05] [R06]
    px_valid && !px_is_space && px_glyph_bit && color_depth == TCA_DEPTH_16
      |=> px_out_color == {8'h00, $past(fore_red_q[7:3]), $past(fore_green_q[7:2]),
                           $past(fore_blue_q[7:3])})
    else $error("16 bit packing wrong");

  fore_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R07]
    reg_wr && reg_addr == ADDR_FORE_GREEN |=> fore_green_q == $past(reg_wdata))
    else $error("foreground green lost");

  back_reset_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R08]
    !back_touched_q |-> back_red_q == BACK_RESET && back_blue_q == BACK_RESET)
    else $error("background not at reset value");

  glyph_top_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R10] [R15]
    reg_wr && reg_addr == ADDR_GLYPH_START3 |=> glyph_start_address[31:24] == $past(reg_wdata))
    else $error("glyph top byte wrong");

  busy_flag_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
    attr_write && engine_busy |=> viol_q)
    else $error("late change not flagged");

  flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
    reg_wr && reg_addr == ADDR_ATTR_STATUS && reg_wdata[STATUS_VIOL_BIT] |=> !viol_q)
    else $error("late change flag not cleared");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
    !reg_rd |=> reg_rdata == REG_ZERO)
    else $error("read data not idle zero");

  glyph_low_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
    reg_wr && reg_addr == ADDR_GLYPH_START0 |=> glyph_start_address[7:0] == $past(reg_wdata))
    else $error("glyph low byte wrong");

  idle_no_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
    !px_valid |=> !px_out_valid && !px_out_write)
    else $error("pixel write without request");

  rsvd_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
    reg_rd && (reg_addr == ADDR_RSVD_B1 || reg_addr == ADDR_RSVD_A0) |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");

  chroma_keep_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
    px_valid && !px_glyph_bit |=> px_out_write == !$past(chroma_key_en))
    else $error("chroma key write wrong");
endmodule : tca_text_color_attr

// File: logic/tca_text_color_attr_fix.sv
// Spare design file slot; carries no logic of its own

// File: bench/tb.sv
// Self-checking bench for the text color attribute register bank
`timescale 1ns/1ps
module tb;
  import tca_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic engine_busy = 1'b0;
  logic [1:0] color_depth = 2'h2;
  logic chroma_key_en = 1'b0;
  logic px_valid = 1'b0;
  logic px_is_space = 1'b0;
  logic px_glyph_bit = 1'b0;
  logic px_out_valid;
  logic px_out_write;
  logic [23:0] px_out_color;
  logic [LINE_GAP_W-1:0] line_gap;
  logic [CHAR_SPACING_W-1:0] char_spacing;
  logic [23:0] fore_color;
  logic [23:0] back_color;
  logic [31:0] glyph_start_address;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] lfsr_q = 16'd20765;
  logic [7:0] exp_q [256];
  logic sticky = 1'b0;

  tca_text_color_attr tca_text_color_attr_inst (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_busy(engine_busy),
    .color_depth(color_depth), .chroma_key_en(chroma_key_en), .px_valid(px_valid),
    .px_is_space(px_is_space), .px_glyph_bit(px_glyph_bit), .px_out_valid(px_out_valid),
    .px_out_write(px_out_write), .px_out_color(px_out_color), .line_gap(line_gap),
    .char_spacing(char_spacing), .fore_color(fore_color), .back_color(back_color),
    .glyph_start_address(glyph_start_address)
  );

  // ==========================================
  // Clock, timeout and verdict
  always #2 mclk = ~mclk;

  task automatic print_verdict();
    $display("counts: compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ==========================================
  // Model helpers
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q[7:0];
  endfunction : rnd

  function automatic logic [23:0] pack(logic [1:0] d, logic [7:0] r, g, b);
    if (d == 2'h0) return {16'h0, r[7:5], g[7:5], b[7:6]};
    if (d == 2'h1) return {8'h0, r[7:3], g[7:2], b[7:3]};
    return {r, g, b};
  endfunction : pack

  function automatic logic [7:0] exp_rd(logic [7:0] a);
    if ((a >= 8'hd0 && a <= 8'hd7) || (a >= 8'hdb && a <= 8'hde)) return exp_q[a];
    if (a == 8'he8) return {6'h0, sticky, engine_busy};
    return 8'h00;
  endfunction : exp_rd

  task automatic model_reset();
    for (int i = 0; i < 256; i++) exp_q[i] = 8'h00;
    exp_q[8'hd2] = 8'hff;
    exp_q[8'hd3] = 8'hff;
    exp_q[8'hd4] = 8'hff;
    sticky = 1'b0;
  endtask : model_reset

  task automatic cmp(string name, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : cmp

  // ==========================================
  // Bus and pixel drivers
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a == 8'hd0) exp_q[a] = d & 8'h1f;
    else exp_q[a] = d;
    if (a == 8'he8 && d[1]) sticky = 1'b0;
    if (a >= 8'hd0 && a <= 8'hd7 && engine_busy) sticky = 1'b1;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    cmp($sformatf("rdata[%h]", a), exp_rd(a), reg_rdata);
  endtask : rd

  task automatic pix(logic sp, logic gb);
    logic fg;
    fg = gb && !sp;
    @(posedge mclk);
    px_valid <= 1'b1;
    px_is_space <= sp;
    px_glyph_bit <= gb;
    @(posedge mclk);
    px_valid <= 1'b0;
    @(negedge mclk);
    cmp("px_out_valid", 1, px_out_valid);
    cmp("px_out_write", fg || !chroma_key_en, px_out_write);
    cmp("px_out_color", fg ? pack(color_depth, exp_q[8'hd2], exp_q[8'hd3], exp_q[8'hd4]) :
        pack(color_depth, exp_q[8'hd5], exp_q[8'hd6], exp_q[8'hd7]), px_out_color);
  endtask : pix

  task automatic chk_fields();
    cmp("line_gap", exp_q[8'hd0][4:0], line_gap);
    cmp("char_spacing", exp_q[8'hd1][5:0], char_spacing);
    cmp("glyph_start", {exp_q[8'hde], exp_q[8'hdd], exp_q[8'hdc], exp_q[8'hdb]},
        glyph_start_address);
  endtask : chk_fields

  // ==========================================
  // Main sequence
  initial begin
    model_reset();
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 8'hce; a <= 8'hdf; a++) rd(a[7:0]);
    cmp("fore_color", 24'hffffff, fore_color);
    cmp("back_color", 24'h000000, back_color);
    chk_fields();
    $display("test reset_values done");
    for (int a = 8'hce; a <= 8'hde; a++) wr(a[7:0], rnd());
    wr(8'hd5, ~exp_q[8'hd2]);
    for (int a = 8'hce; a <= 8'hde; a++) rd(a[7:0]);
    rd(8'h40);
    chk_fields();
    wr(8'hd1, 8'h3f);
    wr(8'hd0, 8'hff);
    rd(8'hd0);
    chk_fields();
    $display("test register_access done");
    for (int d = 0; d < 4; d++) begin
      @(posedge mclk);
      color_depth <= d[1:0];
      @(negedge mclk);
      cmp("fore_color", pack(d[1:0], exp_q[8'hd2], exp_q[8'hd3], exp_q[8'hd4]),
          fore_color);
      cmp("back_color", pack(d[1:0], exp_q[8'hd5], exp_q[8'hd6], exp_q[8'hd7]),
          back_color);
      for (int k = 0; k < 2; k++) begin
        @(posedge mclk);
        chroma_key_en <= k[0];
        pix(1'b0, 1'b1);
        pix(1'b0, 1'b0);
        pix(1'b1, 1'b1);
      end
    end
    $display("test color_and_pixels done");
    @(posedge mclk);
    engine_busy <= 1'b1;
    wr(8'hd5, ~exp_q[8'hd2]);
    rd(8'he8);
    @(posedge mclk);
    engine_busy <= 1'b0;
    wr(8'he8, 8'h02);
    rd(8'he8);
    $display("test busy_status done");
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    model_reset();
    rd(8'hd2);
    rd(8'hdb);
    chk_fields();
    $display("test second_reset done");
    print_verdict();
  end
endmodule : tb
